// file: pkg/quad_uart_pkg.sv
// constants, field positions and state types for the quad uart pin and ready logic
// Behaviour
// R1 - writing one to modem control bit 1 drives that channel's rts_n low
// R2 - after reset every channel's rts_n sits high
// R3 - rts_n follows receive state only when enhanced feature bit 6 enables auto rts
// R4 - rw high reads, rw low writes the register picked by chip select and address
// R5 - serial transmit pin rests high in reset, idle and while transmitter disabled
// R6 - loop-back ignores receive pin and feeds transmit data into own receiver
// R7 - loop-back holds the external transmit pin high; data stays internal
// R8 - receive ready summary goes low when any channel holds a received character
// R9 - receive ready summary returns high once no received character remains
// R10 - transmit ready summary goes low while any channel has a free transmit slot
// R11 - transmit ready summary goes high only when every transmit queue is full
// R12 - host reads each channel's status registers to find which channel needs service
// R13 - address lines 4 and 3 pick channel a, b, c or d under chip select
// R14 - reset clears registers and outputs, disabling transmit and receive paths
package quad_uart_pkg;
   localparam int CHANNELS = 4;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int FIFO_DEPTH = 32;
   localparam int BIT_CYCLES = 16;
   localparam int FRAME_BITS = 10;
   // ----------------------------------------
   // register offsets within a channel
   // ----------------------------------------
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_FEATURE = 3'h2;
   localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
   localparam logic [2:0] OFF_LINE_STATUS = 3'h5;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int MODEM_CTRL_RTS_BIT = 1;
   localparam int MODEM_CTRL_LOOP_BIT = 4;
   localparam int FEATURE_AUTO_RTS_BIT = 6;
   localparam int LSR_RX_FULL_BIT = 0;
   localparam int LSR_TX_ROOM_BIT = 5;
   localparam int LSR_TX_IDLE_BIT = 6;
   localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
   localparam logic [7:0] FEATURE_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum {RX_IDLE, RX_SHIFT} rx_state_t;
endpackage : quad_uart_pkg

// file: pkg/byte_queue_if.sv
// valid/ready carrier between a producer, a queue and its consumer
`timescale 1ns/1ps
interface byte_queue_if #(parameter int W = 8);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport producer (output in_valid, output in_data, input in_ready);
   modport store (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
   modport consumer (input out_valid, input out_data, output out_ready);
endinterface : byte_queue_if

// file: logic/byte_queue.sv
// synchronous queue with parameter width and depth, valid/ready on both sides
`timescale 1ns/1ps
module byte_queue #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   byte_queue_if.store q
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("byte_queue depth must be a power of two, at least 2");
   end
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic push;
   logic pop;
   logic [W-1:0] head_reg;
   logic [PW-1:0] rd_ptr_next;
   assign q.in_ready = (count_reg != (PW+1)'(DEPTH));
   assign q.out_valid = (count_reg != '0);
   assign q.out_data = head_reg;
   assign push = q.in_valid && q.in_ready;
   assign pop = q.out_valid && q.out_ready;
   assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= q.in_data;
      end
      // a byte landing in the head slot bypasses the memory, so the head is never stale
      if (push && wr_ptr_reg == rd_ptr_next) begin
         head_reg <= q.in_data;
      end else begin
         head_reg <= mem[rd_ptr_next];
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         // simultaneous push and pop leaves the level unchanged
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : byte_queue

// file: logic/quad_uart_pin_ready.sv
// four-channel uart pin, strobe decode and summary ready logic
`timescale 1ns/1ps
module quad_uart_pin_ready #(
   parameter int BIT_LEN = quad_uart_pkg::BIT_CYCLES,
   parameter int TX_DEPTH = quad_uart_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic rw,
   input wire logic [quad_uart_pkg::ADDR_W-1:0] register_channel_address_lines,
   input wire logic [quad_uart_pkg::DATA_W-1:0] data_in,
   output logic [quad_uart_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [quad_uart_pkg::CHANNELS-1:0] rx_pin,
   output logic [quad_uart_pkg::CHANNELS-1:0] tx_pin,
   output logic [quad_uart_pkg::CHANNELS-1:0] rts_n,
   output logic receive_ready_summary_n,
   output logic transmit_ready_summary_n
);
   import quad_uart_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   if (BIT_LEN < 4 || BIT_LEN > 65535) begin : g_bad_bit_len
      $error("bit length must lie between 4 and 65535 cycles");
   end
   localparam logic [15:0] BIT_LAST = 16'(BIT_LEN - 1);
   localparam logic [15:0] BIT_HALF = 16'(BIT_LEN / 2);

   // ----------------------------------------
   // bus strobe decode
   // ----------------------------------------
   logic cs_n_reg;
   logic access;
   logic [1:0] chan_sel;
   logic [2:0] reg_sel;
   // one access per chip select assertion; a held strobe is not repeated
   assign access = !cs_n && cs_n_reg;
   // R13 channel from top lines
   assign chan_sel = register_channel_address_lines[4:3];
   assign reg_sel = register_channel_address_lines[2:0];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_n_reg <= 1'b1;
      end else begin
         cs_n_reg <= cs_n;
      end
   end

   logic [CHANNELS-1:0][7:0] modem_ctrl_reg;
   logic [CHANNELS-1:0][7:0] feature_reg;
   logic [CHANNELS-1:0][7:0] rx_hold_reg;
   logic [CHANNELS-1:0] rx_full_reg;
   logic [CHANNELS-1:0] tx_room;
   logic [CHANNELS-1:0] tx_busy;
   logic [CHANNELS-1:0] tx_serial;

   // ----------------------------------------
   // per channel queue, transmitter and receiver
   // ----------------------------------------
   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      byte_queue_if #(.W(DATA_W)) tx_q ();
      tx_state_t tx_state_reg;
      rx_state_t rx_state_reg;
      logic [FRAME_BITS-1:0] tx_shift_reg;
      logic [3:0] tx_bits_reg;
      logic [15:0] tx_cnt_reg;
      logic [3:0] rx_bits_reg;
      logic [15:0] rx_cnt_reg;
      logic [7:0] rx_data_reg;
      logic sel;
      logic loop;
      logic rx_line;
      logic rx_done;
      logic rx_pop;

      assign sel = access && (chan_sel == 2'(c));
      assign loop = modem_ctrl_reg[c][MODEM_CTRL_LOOP_BIT];
      // R6 internal loop path
      assign rx_line = loop ? tx_serial[c] : rx_pin[c];
      assign rx_done = (rx_state_reg == RX_SHIFT) && (rx_cnt_reg == '0)
                       && (rx_bits_reg == 4'(FRAME_BITS - 1)) && rx_line;
      assign rx_pop = sel && rw && (reg_sel == OFF_DATA);
      // R4 low strobe writes data
      assign tx_q.in_valid = sel && !rw && (reg_sel == OFF_DATA);
      assign tx_q.in_data = data_in;
      assign tx_q.out_ready = (tx_state_reg == TX_IDLE);
      assign tx_room[c] = tx_q.in_ready;
      assign tx_busy[c] = (tx_state_reg == TX_SHIFT);
      assign tx_serial[c] = tx_busy[c] ? tx_shift_reg[0] : 1'b1;

      byte_queue #(.W(DATA_W), .DEPTH(TX_DEPTH)) u_tx_queue (
         .sys_clk(sys_clk),
         .reset_n(reset_n),
         .q(tx_q)
      );

      // R4 low strobe writes control
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            modem_ctrl_reg[c] <= MODEM_CTRL_RESET;
            feature_reg[c] <= FEATURE_RESET;
         end else if (sel && !rw) begin
            if (reg_sel == OFF_MODEM_CTRL) begin
               modem_ctrl_reg[c] <= data_in;
            end
            if (reg_sel == OFF_FEATURE) begin
               feature_reg[c] <= data_in;
            end
         end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= '1;
            tx_bits_reg <= '0;
            tx_cnt_reg <= '0;
         end else begin
            unique case (tx_state_reg)
               TX_IDLE: begin
                  if (tx_q.out_valid) begin
                     tx_state_reg <= TX_SHIFT;
                     tx_shift_reg <= {1'b1, tx_q.out_data, 1'b0};
                     tx_bits_reg <= '0;
                     tx_cnt_reg <= BIT_LAST;
                  end
               end
               TX_SHIFT: begin
                  if (tx_cnt_reg != '0) begin
                     tx_cnt_reg <= tx_cnt_reg - 1'b1;
                  end else if (tx_bits_reg == 4'(FRAME_BITS - 1)) begin
                     tx_state_reg <= TX_IDLE;
                  end else begin
                     tx_cnt_reg <= BIT_LAST;
                     tx_bits_reg <= tx_bits_reg + 1'b1;
                     tx_shift_reg <= {1'b1, tx_shift_reg[FRAME_BITS-1:1]};
                  end
               end
            endcase
         end
      end

      // receiver samples each bit at its middle; a bad start bit is dropped
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            rx_state_reg <= RX_IDLE;
            rx_bits_reg <= '0;
            rx_cnt_reg <= '0;
            rx_data_reg <= DATA_RESET;
         end else begin
            unique case (rx_state_reg)
               RX_IDLE: begin
                  if (!rx_line) begin
                     rx_state_reg <= RX_SHIFT;
                     rx_bits_reg <= '0;
                     rx_cnt_reg <= BIT_HALF;
                  end
               end
               RX_SHIFT: begin
                  if (rx_cnt_reg != '0) begin
                     rx_cnt_reg <= rx_cnt_reg - 1'b1;
                  end else begin
                     rx_cnt_reg <= BIT_LAST;
                     rx_bits_reg <= rx_bits_reg + 1'b1;
                     if ((rx_bits_reg == '0 && rx_line)
                         || rx_bits_reg == 4'(FRAME_BITS - 1)) begin
                        rx_state_reg <= RX_IDLE;
                     end else if (rx_bits_reg != '0) begin
                        rx_data_reg <= {rx_line, rx_data_reg[7:1]};
                     end
                  end
               end
            endcase
         end
      end

      // a new character wins over a read in the same cycle
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            rx_full_reg[c] <= 1'b0;
            rx_hold_reg[c] <= DATA_RESET;
         end else if (rx_done) begin
            rx_full_reg[c] <= 1'b1;
            rx_hold_reg[c] <= rx_data_reg;
         end else if (rx_pop) begin
            rx_full_reg[c] <= 1'b0;
         end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            // R2 rts high after reset
            rts_n[c] <= 1'b1;
            // R14 transmit pin idle in reset
            tx_pin[c] <= 1'b1;
         end else begin
            // R3 auto rts gating
            if (feature_reg[c][FEATURE_AUTO_RTS_BIT]) begin
               rts_n[c] <= !(modem_ctrl_reg[c][MODEM_CTRL_RTS_BIT] && !rx_full_reg[c]);
            end else begin
               // R1 software rts drive
               rts_n[c] <= !modem_ctrl_reg[c][MODEM_CTRL_RTS_BIT];
            end
            // R5 R7 idle and loop-back high
            tx_pin[c] <= loop ? 1'b1 : tx_serial[c];
         end
      end

      property p_rts_sw;
         !feature_reg[c][FEATURE_AUTO_RTS_BIT]
            |=> rts_n[c] == !$past(modem_ctrl_reg[c][MODEM_CTRL_RTS_BIT]);
      endproperty
      a_rts_sw: assert property (p_rts_sw) else $error("rts_n not following control bit"); // R1
      property p_auto_rts;
         feature_reg[c][FEATURE_AUTO_RTS_BIT] && rx_full_reg[c] |=> rts_n[c];
      endproperty
      a_auto_rts: assert property (p_auto_rts) else $error("auto rts low while full"); // R3
      property p_tx_idle; !tx_busy[c] ##1 !tx_busy[c] |-> tx_pin[c]; endproperty
      a_tx_idle: assert property (p_tx_idle) else $error("idle transmit pin not high"); // R5
      property p_loop_pin; loop && tx_busy[c] |=> tx_pin[c]; endproperty
      a_loop_pin: assert property (p_loop_pin) else $error("pin driven in loop-back"); // R7
      property p_loop_ignore;
         loop && !tx_busy[c] && rx_state_reg == RX_IDLE |=> rx_state_reg == RX_IDLE;
      endproperty
      a_loop_ignore: assert property (p_loop_ignore) else $error("receive pin seen"); // R6
      c_rx_done: cover property (rx_done);
      c_tx_start: cover property ($rose(tx_busy[c]));
   end

   // ----------------------------------------
   // read data and summary outputs
   // ----------------------------------------
   logic [7:0] read_mux;
   always_comb begin
      read_mux = DATA_RESET;
      unique case (reg_sel)
         OFF_DATA: read_mux = rx_hold_reg[chan_sel];
         OFF_FEATURE: read_mux = feature_reg[chan_sel];
         OFF_MODEM_CTRL: read_mux = modem_ctrl_reg[chan_sel];
         OFF_LINE_STATUS: begin
            read_mux[LSR_RX_FULL_BIT] = rx_full_reg[chan_sel];
            read_mux[LSR_TX_ROOM_BIT] = tx_room[chan_sel];
            read_mux[LSR_TX_IDLE_BIT] = !tx_busy[chan_sel];
         end
         default: read_mux = DATA_RESET;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= DATA_RESET;
         data_oe <= 1'b0;
      end else begin
         // R4 high strobe reads
         data_oe <= !cs_n && rw;
         if (access && rw) begin
            data_out <= read_mux;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         receive_ready_summary_n <= 1'b1;
         transmit_ready_summary_n <= 1'b1;
      end else begin
         // R8 R9 receive wire-or
         receive_ready_summary_n <= !(|rx_full_reg);
         // R10 R11 transmit wire-or
         transmit_ready_summary_n <= !(|tx_room);
      end
   end

   property p_reset_idle; !$past(reset_n) |-> rts_n == '1 && tx_pin == '1; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset"); // R2
   property p_rx_low; |rx_full_reg |=> !receive_ready_summary_n; endproperty
   a_rx_low: assert property (p_rx_low) else $error("receive summary not low"); // R8
   property p_rx_high; rx_full_reg == '0 |=> receive_ready_summary_n; endproperty
   a_rx_high: assert property (p_rx_high) else $error("receive summary not high"); // R9
   property p_tx_low; |tx_room |=> !transmit_ready_summary_n; endproperty
   a_tx_low: assert property (p_tx_low) else $error("transmit summary not low"); // R10
   property p_tx_high; tx_room == '0 |=> transmit_ready_summary_n; endproperty
   a_tx_high: assert property (p_tx_high) else $error("transmit summary not high"); // R11
   property p_ctrl_write;
      access && !rw && reg_sel == OFF_MODEM_CTRL
         |=> modem_ctrl_reg[$past(chan_sel)] == $past(data_in);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R4
   property p_read_oe; !cs_n && rw |=> data_oe; endproperty
   a_read_oe: assert property (p_read_oe) else $error("read enable missing"); // R4
   c_tx_full: cover property (transmit_ready_summary_n);
endmodule : quad_uart_pin_ready

// file: dv/serial_far_end.sv
// far-end serial model: drives frames into the receive pins, captures transmit frames
`timescale 1ns/1ps
module serial_far_end #(
   parameter int BL = 4
) (
   input wire logic sys_clk,
   input wire logic [3:0] tx_pin,
   output logic [3:0] rx_pin
);
   // ----------------------------------------
   // line driver
   // ----------------------------------------
   // lines rest high like a real modem output, so a missed frame reads as idle
   initial rx_pin = 4'hf;

   // one 8n1 frame, lsb first, each bit held BL cycles
   task automatic send(input int ch, input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         rx_pin[ch] <= f[i];
         repeat (BL - 1) @(posedge sys_clk);
      end
   endtask : send

   // ----------------------------------------
   // line monitor
   // ----------------------------------------
   // samples on the falling clock edge, clear of the pin register's update
   task automatic capture(input int ch, output logic [7:0] b, output bit ok);
      int n;
      n = 0;
      while (tx_pin[ch] !== 1'b0 && n < 20 * BL) begin
         @(negedge sys_clk);
         n++;
      end
      repeat (BL / 2) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BL) @(negedge sys_clk);
         b[i] = tx_pin[ch];
      end
      repeat (BL) @(negedge sys_clk);
      ok = (n < 20 * BL) && (tx_pin[ch] === 1'b1);
   endtask : capture
endmodule : serial_far_end

// file: dv/quad_uart_pin_ready_tb.sv
// self-checking bench for the quad uart pin and ready logic
`timescale 1ns/1ps
module quad_uart_pin_ready_tb;
   import quad_uart_pkg::*;
   // long bit time so four full queues cannot drain while they are filled
   localparam int BL = 64;
   typedef struct {int ch; logic [7:0] val; logic [3:0] rts;} row_t;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cs_n = 1'b1;
   logic rw = 1'b1;
   logic [ADDR_W-1:0] addr = 5'h00;
   logic [DATA_W-1:0] data_in = 8'h00;
   logic [DATA_W-1:0] data_out;
   logic data_oe;
   logic [CHANNELS-1:0] rx_pin;
   logic [CHANNELS-1:0] tx_pin;
   logic [CHANNELS-1:0] rts_n;
   logic rsum_n;
   logic tsum_n;
   int fails = 0;
   int n_checks = 0;
   int lows;
   logic [7:0] q;
   logic [7:0] b;
   bit ok;
   row_t rows [7] = '{'{0, 8'h02, 4'he}, '{1, 8'h02, 4'hc}, '{2, 8'h02, 4'h8},
      '{3, 8'h02, 4'h0}, '{1, 8'h00, 4'h2}, '{3, 8'h01, 4'ha}, '{0, 8'h00, 4'hb}};

   always #4 sys_clk = ~sys_clk;

   quad_uart_pin_ready #(.BIT_LEN(BL), .TX_DEPTH(FIFO_DEPTH)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .rw(rw),
      .register_channel_address_lines(addr), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .rx_pin(rx_pin), .tx_pin(tx_pin), .rts_n(rts_n),
      .receive_ready_summary_n(rsum_n), .transmit_ready_summary_n(tsum_n));

   serial_far_end #(.BL(BL)) far (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // one access; cs_n back high for an edge so the next one is taken afresh
   task automatic bus(input logic r, input int ch, input logic [2:0] off, input logic [7:0] d);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      rw <= r;
      addr <= {ch[1:0], off};
      data_in <= d;
      @(posedge sys_clk);
      cs_n <= 1'b1;
      #1;
      if (r) chk("data_oe", 8'(data_oe), 8'h01);
      tick(1);
      q = data_out;
   endtask : bus

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   initial begin
      #(8 * 30000);
      fails++;
      test_done();
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      tick(1);
      chk("tx_pin", 8'(tx_pin), 8'h0f);
      chk("rts_n", 8'(rts_n), 8'h0f);
      chk("summaries", 8'({rsum_n, tsum_n}), 8'h03);
      chk("data_oe", 8'(data_oe), 8'h00);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      tick(2);
      chk("tx summary", 8'(tsum_n), 8'h00);
      bus(1'b1, 0, OFF_LINE_STATUS, 8'h00);
      chk("line status", q & 8'h61, 8'h60);
      foreach (rows[i]) begin
         bus(1'b0, rows[i].ch, OFF_MODEM_CTRL, rows[i].val);
         chk("rts_n", 8'(rts_n), 8'(rows[i].rts));
      end
      // auto rts on channel 2 only, channel 1 stays a plain output
      bus(1'b0, 2, OFF_FEATURE, 8'h40);
      bus(1'b0, 2, OFF_MODEM_CTRL, 8'h02);
      bus(1'b0, 1, OFF_MODEM_CTRL, 8'h02);
      chk("rts_n", 8'(rts_n), 8'h09);
      fork
         far.send(1, 8'h5a);
         far.send(2, 8'h81);
      join
      tick(3);
      chk("rts_n", 8'(rts_n), 8'h0d);
      chk("rx summary", 8'(rsum_n), 8'h00);
      bus(1'b1, 2, OFF_LINE_STATUS, 8'h00);
      chk("line status", q & 8'h01, 8'h01);
      bus(1'b1, 2, OFF_DATA, 8'h00);
      chk("rx data", q, 8'h81);
      tick(1);
      chk("rts_n", 8'(rts_n), 8'h09);
      chk("rx summary", 8'(rsum_n), 8'h00);
      bus(1'b1, 1, OFF_DATA, 8'h00);
      chk("rx data", q, 8'h5a);
      tick(2);
      chk("rx summary", 8'(rsum_n), 8'h01);
      chk("tx_pin", 8'(tx_pin), 8'h0f);
      fork
         bus(1'b0, 3, OFF_DATA, 8'hc5);
         far.capture(3, b, ok);
      join
      chk("tx frame", b, 8'hc5);
      chk("stop bit", 8'(ok), 8'h01);
      // loop-back: a foreign frame on the pin must not reach the receiver
      bus(1'b0, 0, OFF_MODEM_CTRL, 8'h12);
      lows = 0;
      fork
         bus(1'b0, 0, OFF_DATA, 8'ha5);
         far.send(0, 8'h3c);
         repeat (12 * BL) begin
            @(negedge sys_clk);
            if (tx_pin[0] !== 1'b1) lows++;
         end
      join
      chk("tx low cycles", lows[7:0], 8'h00);
      bus(1'b1, 0, OFF_DATA, 8'h00);
      chk("loop data", q, 8'ha5);
      // fill every transmit queue past its depth; extra writes are dropped
      for (int c = 0; c < 4; c++) begin
         if (c == 3) chk("tx summary", 8'(tsum_n), 8'h00);
         repeat (40) bus(1'b0, c, OFF_DATA, 8'h30);
      end
      tick(2);
      chk("tx summary", 8'(tsum_n), 8'h01);
      lows = 0;
      while (tsum_n !== 1'b0 && lows < 25 * BL) begin
         tick(1);
         lows++;
      end
      chk("tx summary", 8'(tsum_n), 8'h00);
      // reset in mid-frame: every pin falls back to idle at once
      @(posedge sys_clk);
      reset_n <= 1'b0;
      tick(1);
      chk("tx_pin", 8'(tx_pin), 8'h0f);
      chk("rts_n", 8'(rts_n), 8'h0f);
      chk("summaries", 8'({rsum_n, tsum_n}), 8'h03);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      tick(2);
      chk("rts_n", 8'(rts_n), 8'h0f);
      chk("tx summary", 8'(tsum_n), 8'h00);
      bus(1'b1, 0, OFF_MODEM_CTRL, 8'h00);
      chk("control after reset", q, 8'h00);
      bus(1'b1, 0, OFF_LINE_STATUS, 8'h00);
      chk("line status", q & 8'h61, 8'h60);
      test_done();
   end
endmodule : quad_uart_pin_ready_tb
